// file: src/hwtcs_map.vh
// constants for the hardware-mode clock and termination select block
`ifndef HWTCS_MAP_VH
`define HWTCS_MAP_VH

// bus interface select codes (hardware control mode)
`define HWTCS_BIS_HW          2'b11
// transmit clock source select codes
`define HWTCS_TCS_TX_CLK_IN        2'b00
`define HWTCS_TCS_PLL         2'b01
`define HWTCS_TCS_MCLK        2'b10
`define HWTCS_TCS_RCLK        2'b11
// mode code classes
`define HWTCS_E1_FRM_HI       2'b01
`define HWTCS_E1_SYNC         4'h8
`define HWTCS_T1_HI           2'b00
`define HWTCS_CC_HI           2'b10
// termination value codes
`define HWTCS_TERM_OFF        3'h0
`define HWTCS_TERM_75         3'h1
`define HWTCS_TERM_100        3'h2
`define HWTCS_TERM_110        3'h3
`define HWTCS_TERM_120        3'h4
// fixed states of non pin-controllable functions
`define HWTCS_FIXED_CTRL      8'h00
// wishbone register byte addresses
`define HWTCS_REG_CLK         4'h0
`define HWTCS_REG_TERM        4'h4
`define HWTCS_REG_MODE        4'h8
`define HWTCS_REG_CTRL        4'hc
// field positions
`define HWTCS_CTRL_SW_EN      0
// reset values
`define HWTCS_CTRL_RST        1'b0
`define HWTCS_DIV_RST         4'h0
// master clock scaling divider (enable every 8 cycles)
`define HWTCS_MCLK_DIV_LAST   4'h7

`endif

// file: src/hwtcs_term_dec.v
// termination value decoder for one direction
`timescale 1ns/1ps

module hwtcs_term_dec (
    mode,
    disable_pin,
    e1_term_sel,
    term
);
    `include "hwtcs_map.vh"
    input  wire [3:0] mode;
    input  wire       disable_pin;
    input  wire       e1_term_sel;
    output reg  [2:0] term;

    // e1 framed codes 0100..0111 plus the 2048khz sync code
    wire is_e1 = (mode[3:2] == `HWTCS_E1_FRM_HI) ||
                 (mode == `HWTCS_E1_SYNC);

    // disable wins, else value follows mode class
    always @* begin
        if (disable_pin) begin
            term = `HWTCS_TERM_OFF;
        end else if (is_e1) begin
            term = e1_term_sel ? `HWTCS_TERM_120
                               : `HWTCS_TERM_75;
        end else if (mode[3:2] == `HWTCS_T1_HI) begin
            term = `HWTCS_TERM_100;
        end else if (mode[3:2] == `HWTCS_CC_HI) begin
            term = `HWTCS_TERM_110;
        end else begin
            term = `HWTCS_TERM_OFF;
        end
    end
endmodule

// file: src/hwtcs_top.v
// hardware-mode transmit clock and termination select logic
`timescale 1ns/1ps

module hwtcs_top (
    clk,
    resetn,
    bus_iface_select_0,
    bus_iface_select_1,
    cs_rlb_pin,
    rd_pin,
    wr_pin,
    addr_data_bit0,
    addr_data_bit1,
    tx_clk_src_sel_1,
    tx_mode_lo,
    rx_mode_lo,
    tx_term_disable,
    rx_term_disable,
    e1_term_sel,
    tx_clk_in,
    pll_clk_in,
    rclk_in,
    wb_adr_i,
    wb_dat_i,
    wb_dat_o,
    wb_we_i,
    wb_sel_i,
    wb_cyc_i,
    wb_stb_i,
    wb_ack_o,
    hw_mode_ff,
    pll_ref_ff,
    tx_clock_ff,
    pll_out_ff,
    remote_loopback_en_ff,
    tx_term_ff,
    rx_term_ff,
    fixed_ctrl_ff
);
    `include "hwtcs_map.vh"
    input  wire        clk;
    input  wire        resetn;
    input  wire        bus_iface_select_0;
    input  wire        bus_iface_select_1;
    input  wire        cs_rlb_pin;
    input  wire        rd_pin;
    input  wire        wr_pin;
    input  wire        addr_data_bit0;
    input  wire        addr_data_bit1;
    input  wire        tx_clk_src_sel_1;
    input  wire [2:0]  tx_mode_lo;
    input  wire [1:0]  rx_mode_lo;
    input  wire        tx_term_disable;
    input  wire        rx_term_disable;
    input  wire        e1_term_sel;
    input  wire        tx_clk_in;
    input  wire        pll_clk_in;
    input  wire        rclk_in;
    input  wire [3:0]  wb_adr_i;
    input  wire [31:0] wb_dat_i;
    output reg  [31:0] wb_dat_o;
    input  wire        wb_we_i;
    input  wire [3:0]  wb_sel_i;
    input  wire        wb_cyc_i;
    input  wire        wb_stb_i;
    output reg         wb_ack_o;
    output reg         hw_mode_ff;
    output reg         pll_ref_ff;
    output reg         tx_clock_ff;
    output reg         pll_out_ff;
    output reg         remote_loopback_en_ff;
    output reg  [2:0]  tx_term_ff;
    output reg  [2:0]  rx_term_ff;
    output reg  [7:0]  fixed_ctrl_ff;

    // =======================================================
    // pin synchronisers
    // =======================================================
    // one entry per pin that crosses into the clock domain
    localparam NSYNC = 19;

    wire [NSYNC-1:0] pin_raw;
    reg  [NSYNC-1:0] pin_meta_ff;
    reg  [NSYNC-1:0] pin_sync_ff;

    // straps and shared port pins, bits 7:0
    assign pin_raw[7:0]   = {tx_clk_src_sel_1, addr_data_bit1, addr_data_bit0,
                             wr_pin, rd_pin, cs_rlb_pin,
                             bus_iface_select_1, bus_iface_select_0};
    // mode and termination straps, bits 15:8
    assign pin_raw[15:8]  = {e1_term_sel, rx_term_disable, tx_term_disable,
                             rx_mode_lo, tx_mode_lo};
    // clock sources, bits 18:16
    assign pin_raw[18:16] = {rclk_in, pll_clk_in, tx_clk_in};

    // two flops per pin, one generate entry per bit
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            always @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    pin_meta_ff[gi] <= 1'b0;
                    pin_sync_ff[gi] <= 1'b0;
                end else begin
                    pin_meta_ff[gi] <= pin_raw[gi];
                    pin_sync_ff[gi] <= pin_meta_ff[gi];
                end
            end
        end
    endgenerate

    // bus interface select straps
    wire       s_bis0   = pin_sync_ff[0];
    wire       s_bus_iface_select_1   = pin_sync_ff[1];

    // shared port pins reused as straps in hardware mode
    wire       s_cs     = pin_sync_ff[2];
    wire       s_rd     = pin_sync_ff[3];
    wire       s_wr     = pin_sync_ff[4];
    wire       s_ad0    = pin_sync_ff[5];
    wire       s_ad1    = pin_sync_ff[6];
    wire       s_tx_clk_src_sel_1  = pin_sync_ff[7];

    // mode and termination straps
    wire [2:0] s_tmlo   = pin_sync_ff[10:8];
    wire [1:0] s_rmlo   = pin_sync_ff[12:11];
    wire       s_tx_term_disable   = pin_sync_ff[13];
    wire       s_rx_term_disable   = pin_sync_ff[14];
    wire       s_e1_term_sel   = pin_sync_ff[15];

    // clock sources, only ever sampled as levels
    wire       s_tx_clk_in   = pin_sync_ff[16];
    wire       s_pllclk = pin_sync_ff[17];
    wire       s_rclk   = pin_sync_ff[18];

    // =======================================================
    // mode decode and pin remapping
    // =======================================================
    // hardware mode needs both bus select straps high
    wire       hw_mode = ({s_bus_iface_select_1, s_bis0} == `HWTCS_BIS_HW);

    // hardware-mode reuse of port pins as clock and mode selects
    wire [1:0] tx_src_pins = {s_tx_clk_src_sel_1, s_ad0};
    wire [3:0] rx_mode_pins = {s_ad1, s_rd, s_rmlo};
    wire [3:0] tx_mode_pins = {s_wr, s_tmlo};

    // =======================================================
    // software overrides over wishbone
    // =======================================================
    // override registers, never used in hardware mode
    reg        sw_en_ff;
    reg  [1:0] sw_tx_src_ff;
    reg  [3:0] sw_rx_mode_ff;
    reg  [3:0] sw_tx_mode_ff;

    // processor modes use software values while sw_en_ff is set, else pins; hardware mode uses pins
    wire [1:0] tx_src  = (hw_mode || !sw_en_ff) ? tx_src_pins
                                                : sw_tx_src_ff;
    wire [3:0] rx_mode = (hw_mode || !sw_en_ff) ? rx_mode_pins
                                                : sw_rx_mode_ff;
    wire [3:0] tx_mode = (hw_mode || !sw_en_ff) ? tx_mode_pins
                                                : sw_tx_mode_ff;

    // =======================================================
    // master clock scaler
    // =======================================================
    reg  [3:0] div_ff;
    reg        mclk_en_ff;
    reg        mclk_scaled_ff;
    wire       div_wrap = (div_ff == `HWTCS_MCLK_DIV_LAST);
    wire [3:0] nxt_div  = div_wrap ? `HWTCS_DIV_RST : div_ff + 4'h1;

    // divider makes a one-cycle enable pulse on each wrap
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_ff     <= `HWTCS_DIV_RST;
            mclk_en_ff <= 1'b0;
        end else begin
            div_ff     <= nxt_div;
            mclk_en_ff <= div_wrap;
        end
    end

    // scaled master clock level flips once per enable pulse
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mclk_scaled_ff <= 1'b0;
        end else if (mclk_en_ff) begin
            mclk_scaled_ff <= ~mclk_scaled_ff;
        end
    end

    // =======================================================
    // transmit clock select and termination
    // =======================================================
    // selected transmit clock level ahead of its output flop
    reg nxt_tx_clock;

    // four-way source mux
    always @* begin
        case (tx_src)
            `HWTCS_TCS_TX_CLK_IN: nxt_tx_clock = s_tx_clk_in;
            `HWTCS_TCS_PLL:  nxt_tx_clock = s_pllclk;
            `HWTCS_TCS_MCLK: nxt_tx_clock = mclk_scaled_ff;
            default:         nxt_tx_clock = s_rclk;
        endcase
    end

    // decoded termination per direction
    wire [2:0] tx_term_dec;
    wire [2:0] rx_term_dec;

    // one shared e1 select feeds both directions
    hwtcs_term_dec u_tx_term (
        .mode        (tx_mode),
        .disable_pin (s_tx_term_disable),
        .e1_term_sel (s_e1_term_sel),
        .term        (tx_term_dec)
    );

    hwtcs_term_dec u_rx_term (
        .mode        (rx_mode),
        .disable_pin (s_rx_term_disable),
        .e1_term_sel (s_e1_term_sel),
        .term        (rx_term_dec)
    );

    // clock routing outputs follow the bus select straps, tx clock pin and source mux every cycle
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hw_mode_ff  <= 1'b0;
            pll_ref_ff  <= 1'b0;
            tx_clock_ff <= 1'b0;
            pll_out_ff  <= 1'b0;
        end else begin
            hw_mode_ff  <= hw_mode;
            pll_ref_ff  <= s_tx_clk_in;
            tx_clock_ff <= nxt_tx_clock;
            pll_out_ff  <= nxt_tx_clock;
        end
    end

    // loopback enable and fixed states of other functions
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            remote_loopback_en_ff <= 1'b0;
            fixed_ctrl_ff         <= `HWTCS_FIXED_CTRL;
        end else begin
            remote_loopback_en_ff <= hw_mode & s_cs;
            fixed_ctrl_ff         <= `HWTCS_FIXED_CTRL;
        end
    end

    // termination applies in hardware mode only, no write needed
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_term_ff <= `HWTCS_TERM_OFF;
            rx_term_ff <= `HWTCS_TERM_OFF;
        end else if (hw_mode) begin
            tx_term_ff <= tx_term_dec;
            rx_term_ff <= rx_term_dec;
        end else begin
            tx_term_ff <= `HWTCS_TERM_OFF;
            rx_term_ff <= `HWTCS_TERM_OFF;
        end
    end

    // =======================================================
    // wishbone slave
    // =======================================================
    // a request is taken once; the ack cycle never restarts it
    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    reg  [31:0] nxt_rdata;

    // read words, one per register
    wire [31:0] clk_word  = {29'h0, pll_out_ff, tx_src};
    wire [31:0] term_word = {26'h0, rx_term_ff, tx_term_ff};
    wire [31:0] mode_word = {22'h0, remote_loopback_en_ff, hw_mode_ff,
                             rx_mode, tx_mode};
    wire [31:0] ctrl_word = {21'h0, sw_tx_src_ff, sw_rx_mode_ff,
                             sw_tx_mode_ff, sw_en_ff};

    // address decode, unmapped offsets read zero
    always @* begin
        if (wb_adr_i == `HWTCS_REG_CLK) begin
            nxt_rdata = clk_word;
        end else if (wb_adr_i == `HWTCS_REG_TERM) begin
            nxt_rdata = term_word;
        end else if (wb_adr_i == `HWTCS_REG_MODE) begin
            nxt_rdata = mode_word;
        end else if (wb_adr_i == `HWTCS_REG_CTRL) begin
            nxt_rdata = ctrl_word;
        end else begin
            nxt_rdata = 32'h0;
        end
    end

    // one-cycle ack; only the control register is writable
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o      <= 1'b0;
            wb_dat_o      <= 32'h0;
            sw_en_ff      <= `HWTCS_CTRL_RST;
            sw_tx_src_ff  <= 2'h0;
            sw_rx_mode_ff <= 4'h0;
            sw_tx_mode_ff <= 4'h0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? nxt_rdata : 32'h0;
            if (wb_req && wb_we_i && (wb_adr_i == `HWTCS_REG_CTRL)) begin
                // lane 0: enable, tx mode, low rx mode bits
                if (wb_sel_i[0]) begin
                    sw_en_ff         <= wb_dat_i[`HWTCS_CTRL_SW_EN];
                    sw_tx_mode_ff    <= wb_dat_i[4:1];
                    sw_rx_mode_ff[2:0] <= wb_dat_i[7:5];
                end
                // lane 1: top rx mode bit and clock source
                if (wb_sel_i[1]) begin
                    sw_rx_mode_ff[3] <= wb_dat_i[8];
                    sw_tx_src_ff     <= wb_dat_i[10:9];
                end
            end
        end
    end
endmodule

// file: tb/hwtcs_clk_src.sv
// far-side clock sources feeding the block's clock inputs
`timescale 1ns/1ps
module hwtcs_clk_src (
    input  wire logic clk,
    input  wire logic resetn,
    output wire logic tx_clk_in,
    output wire logic pll_clk_in,
    output wire logic rclk_in
);
    logic [4:0] div_ff;

    // free running divider, the block samples these only as levels
    always @(posedge clk or negedge resetn) begin
        if (!resetn) div_ff <= 5'h00;
        else div_ff <= div_ff + 5'h01;
    end
    // three sources with different patterns so a wrong pick shows
    assign tx_clk_in  = div_ff[1];
    assign pll_clk_in = div_ff[2] ^ div_ff[0];
    assign rclk_in    = div_ff[3];
endmodule

// file: tb/hwtcs_props.sv
// assertions watching the ports of the clock and termination block
`timescale 1ns/1ps
module hwtcs_props (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       bus_iface_select_0,
    input wire logic       bus_iface_select_1,
    input wire logic       cs_rlb_pin,
    input wire logic       rd_pin,
    input wire logic       addr_data_bit0,
    input wire logic       addr_data_bit1,
    input wire logic       tx_clk_src_sel_1,
    input wire logic [1:0] rx_mode_lo,
    input wire logic       tx_term_disable,
    input wire logic       rx_term_disable,
    input wire logic       e1_term_sel,
    input wire logic       tx_clk_in,
    input wire logic       pll_clk_in,
    input wire logic       rclk_in,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    input wire logic       hw_mode_ff,
    input wire logic       pll_ref_ff,
    input wire logic       tx_clock_ff,
    input wire logic       pll_out_ff,
    input wire logic       remote_loopback_en_ff,
    input wire logic [2:0] tx_term_ff,
    input wire logic [2:0] rx_term_ff,
    input wire logic [7:0] fixed_ctrl_ff
);
    // pin decode seen three edges before each output
    wire       hw  = bus_iface_select_0 & bus_iface_select_1;
    wire [3:0] rxm = {addr_data_bit1, rd_pin, rx_mode_lo};
    wire       e1r = (rxm[3:2] == 2'b01) || (rxm == 4'h8);
    wire       rx_e1_on = hw & ~rx_term_disable & e1r;
    wire [2:0] rxe = e1_term_sel ? 3'h4 : 3'h1;
    wire [1:0] src = {tx_clk_src_sel_1, addr_data_bit0};
    wire       srcv = (src == 2'b00) ? tx_clk_in :
                      (src == 2'b01) ? pll_clk_in : rclk_in;
    wire       hw_rlb = hw & cs_rlb_pin;
    logic [2:0] cnt_ff;
    // edges since reset, so $past never reaches into reset
    always @(posedge clk or negedge resetn) begin
        if (!resetn) cnt_ff <= 3'h0;
        else if (cnt_ff != 3'h7) cnt_ff <= cnt_ff + 3'h1;
    end
    wire ok = (cnt_ff >= 3'h4);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    a_pll_ref_pin: assert property (
        ok |-> pll_ref_ff == $past(tx_clk_in, 3))
        else $error("pll reference is not the tx clock pin");
    a_pll_out_same: assert property (
        pll_out_ff == tx_clock_ff)
        else $error("pll output differs from tx clock");
    a_src_mux_sel: assert property (
        ok && $past(hw, 3) && $past(src, 3) != 2'b10
        |-> tx_clock_ff == $past(srcv, 3))
        else $error("tx clock source pick wrong");
    a_rlb_hw_only: assert property (
        ok |-> remote_loopback_en_ff == $past(hw_rlb, 3))
        else $error("remote loopback wrong");
    a_fixed_ctrl: assert property (
        fixed_ctrl_ff == 8'h00)
        else $error("fixed control state moved");
    a_term_sw_off: assert property (
        ok && !$past(hw, 3) |-> tx_term_ff == 3'h0 && rx_term_ff == 3'h0)
        else $error("termination on outside hardware mode");
    a_tx_dis_off: assert property (
        ok && $past(tx_term_disable, 3) |-> tx_term_ff == 3'h0)
        else $error("tx termination not off");
    a_rx_dis_off: assert property (
        ok && $past(rx_term_disable, 3) |-> rx_term_ff == 3'h0)
        else $error("rx termination not off");
    a_rx_e1_val: assert property (
        ok && $past(rx_e1_on, 3) |-> rx_term_ff == $past(rxe, 3))
        else $error("rx e1 termination value wrong");
    a_hw_mode_pins: assert property (
        ok |-> hw_mode_ff == $past(hw, 3))
        else $error("hardware mode flag does not follow the straps");
    a_wb_ack_one: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus acknowledge not a single cycle");
endmodule
bind hwtcs_top hwtcs_props u_props (.clk, .resetn, .bus_iface_select_0,
    .bus_iface_select_1, .cs_rlb_pin, .rd_pin, .addr_data_bit0,
    .addr_data_bit1, .tx_clk_src_sel_1, .rx_mode_lo, .tx_term_disable,
    .rx_term_disable, .e1_term_sel, .tx_clk_in, .pll_clk_in, .rclk_in,
    .wb_cyc_i, .wb_stb_i, .wb_ack_o, .hw_mode_ff, .pll_ref_ff, .tx_clock_ff,
    .pll_out_ff, .remote_loopback_en_ff, .tx_term_ff, .rx_term_ff,
    .fixed_ctrl_ff);

// file: tb/tb_top.sv
// self-checking bench for the clock and termination select block
`timescale 1ns/1ps
`include "hwtcs_map.vh"
module tb_top;
    logic        clk = 0, resetn = 0, bus_iface_select_0 = 0;
    logic        bus_iface_select_1 = 0, cs_rlb_pin = 0, rd_pin = 0;
    logic        wr_pin = 0, addr_data_bit0 = 0, addr_data_bit1 = 0;
    logic        tx_clk_src_sel_1 = 0, tx_term_disable = 0;
    logic        rx_term_disable = 0, e1_term_sel = 0;
    logic [2:0]  tx_mode_lo = 0;
    logic [1:0]  rx_mode_lo = 0;
    logic [3:0]  wb_adr_i = 0;
    logic [31:0] wb_dat_i = 0;
    logic        wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
    wire         tx_clk_in, pll_clk_in, rclk_in, wb_ack_o;
    wire [31:0]  wb_dat_o;
    logic [31:0] exp_q[$], msk_q[$];
    int          n_errors = 0, n_compared = 0;
    integer      seed = 32'heaa0bb3d;

    hwtcs_clk_src u_src (.clk, .resetn, .tx_clk_in, .pll_clk_in, .rclk_in);
    hwtcs_top DUT (.clk, .resetn, .bus_iface_select_0, .bus_iface_select_1,
        .cs_rlb_pin, .rd_pin, .wr_pin, .addr_data_bit0, .addr_data_bit1,
        .tx_clk_src_sel_1, .tx_mode_lo, .rx_mode_lo, .tx_term_disable,
        .rx_term_disable, .e1_term_sel, .tx_clk_in, .pll_clk_in, .rclk_in,
        .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i(4'hf),
        .wb_cyc_i, .wb_stb_i, .wb_ack_o, .hw_mode_ff(), .pll_ref_ff(),
        .tx_clock_ff(), .pll_out_ff(), .remote_loopback_en_ff(),
        .tx_term_ff(), .rx_term_ff(), .fixed_ctrl_ff());

    initial forever #2 clk = ~clk;

    task give_verdict;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task check(input [31:0] seen, input [31:0] expv, input string what);
        n_compared++;
        if (seen !== expv) begin
            n_errors++;
            $display("[FAIL] %s exp %h seen %h", what, expv, seen);
        end
    endtask

    // classic cycle: hold until ack is sampled high, then release
    task wb(input [3:0] a, input w, input [31:0] d, e, m);
        int i;
        if (!w) begin
            exp_q.push_back(e);
            msk_q.push_back(m);
        end
        @(posedge clk);
        {wb_adr_i, wb_we_i, wb_dat_i, wb_cyc_i, wb_stb_i} <= {a, w, d, 2'b11};
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 20);
        if (i >= 20) begin
            n_errors++;
            give_verdict();
        end
        {wb_we_i, wb_cyc_i, wb_stb_i} <= 3'b000;
    endtask

    // expected termination code for one direction
    function [2:0] term(input [3:0] md, input dis, input sel);
        if (dis) term = `HWTCS_TERM_OFF;
        else if (md[3:2] == 2'b01 || md == 4'h8)
            term = sel ? `HWTCS_TERM_120 : `HWTCS_TERM_75;
        else if (md[3:2] == 2'b00) term = `HWTCS_TERM_100;
        else term = `HWTCS_TERM_110;
    endfunction

    // read results are compared against the oldest note
    always @(posedge clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            check(wb_dat_o & msk_q[0], exp_q[0] & msk_q[0], "wb read");
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end

    initial begin
        logic [15:0] r;
        logic [2:0]  tt, rt;
        logic        hw;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        wb(4'hc, 0, 0, 0, 32'h7ff);
        wb(4'hc, 1, 32'h5a4, 0, 0);
        wb(4'hc, 0, 0, 32'h5a4, 32'h7ff);
        wb(4'hc, 1, 0, 0, 0);
        wb(4'h2, 0, 0, 0, 32'hffffffff);
        for (int i = 0; i < 40; i++) begin
            r = $random(seed);
            if (i >= 8) r[15:14] = 2'b11;
            else begin
                if (r[15:14] == 2'b11) r[15] = 1'b0;
                {r[12], r[11]} = 2'b00;
            end
            if (i >= 8) {r[8], r[10]} = i[1:0];
            if (r[11] & r[7]) r[11] = 1'b0;
            if (r[9] & r[12]) r[9] = 1'b0;
            @(posedge clk);
            {bus_iface_select_0, bus_iface_select_1, cs_rlb_pin, rd_pin,
             wr_pin, addr_data_bit0, addr_data_bit1, tx_clk_src_sel_1,
             tx_mode_lo, rx_mode_lo, tx_term_disable, rx_term_disable,
             e1_term_sel} <= r;
            repeat (5) @(posedge clk);
            tt = (i >= 8) ? term({r[11], r[7:5]}, r[2], r[0]) : 3'h0;
            rt = (i >= 8) ? term({r[9], r[12], r[4:3]}, r[1], r[0]) : 3'h0;
            wb(4'h4, 0, 0, {26'h0, rt, tt}, 32'h3f);
            hw = (i >= 8);
            wb(4'h8, 0, 0, {22'h0, hw & r[13], hw, r[9], r[12], r[4:3],
                            r[11], r[7:5]}, 32'h3ff);
            if (i >= 8) wb(4'h0, 0, 0, {30'h0, i[1:0]}, 32'h3);
        end
        repeat (4) @(posedge clk);
        check(exp_q.size(), 0, "notes left");
        give_verdict();
    end
endmodule
